//--- include/ffs_pkg.sv
// Package: register map, field positions and timing for the fault status flag bank
package ffs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_GEN_STATUS  = 8'h02;
  localparam logic [7:0] ADDR_FAULT_ONE   = 8'h05;
  localparam logic [7:0] ADDR_FAULT_TWO   = 8'h06;
  localparam logic [7:0] FAULT_ONE_RESET  = 8'h00;
  localparam logic [7:0] FAULT_TWO_RESET  = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned BIT_ALERT_RELEASE  = 7;
  localparam int unsigned BIT_REG_OVERLOAD   = 4;
  localparam int unsigned BIT_THERMAL        = 3;
  localparam int unsigned BIT_SWITCH_OC      = 2;
  localparam int unsigned BIT_WATCHDOG       = 7;
  localparam int unsigned BIT_HICCUP         = 6;
  localparam int unsigned BIT_INPUT_UV       = 5;
  localparam int unsigned BIT_OUTPUT_OV      = 4;
  localparam int unsigned BIT_LIGHT_LOAD     = 3;
  localparam int unsigned BIT_INPUT_OV       = 2;
  localparam int unsigned BIT_BUS_ERROR      = 1;
  localparam int unsigned BIT_ALERT_LEVEL    = 6;

  // ****************************************
  // Timing
  // ****************************************
  localparam longint unsigned CLK_HZ             = 20_000_000;
  localparam longint unsigned REG_RESTART_MS     = 100;
  localparam longint unsigned REG_RESTART_CYCLES = (REG_RESTART_MS * CLK_HZ) / 1000;

  // Raw fault conditions from the analog and control side
  typedef struct packed {
    logic reg_overcurrent;
    logic reg_undervoltage;
    logic thermal;
    logic switch_oc;
    logic watchdog_expired;
    logic hiccup;
    logic input_uv;
    logic output_ov;
    logic light_load_off;
    logic input_ov;
    logic bus_error;
  } ffs_cond_t;

  typedef struct packed {
    logic [7:0] fault_one;
    logic [7:0] fault_two;
    logic       alert_active;
    logic [7:0] rdata;
    logic       rvalid;
    logic [31:0] restart_cnt;
    logic       alert_drive;
    ffs_cond_t  cond_meta;
    ffs_cond_t  cond_sync;
    ffs_cond_t  cond_prev;
    logic       pin_meta;
    logic       pin_sync;
  } ffs_state_t;

endpackage : ffs_pkg

//--- hw/ffs_fault_flags.sv
// Fault status flag bank with open-drain alert output
//
// Contract
// - Writing one to bit 7 of fault_flags_one releases alert; bit self-clears.
// - Alert may stay asserted after release while a fault is still present.
// - General status 0x02 bit 6 shows the live alert pin level.
// - Bit 4 of fault_flags_one latches regulator overload; host read clears it.
// - Regulator overload bit sets regardless of the regulator fault mask.
// - After regulator overcurrent, read cannot clear until 100 ms restart delay passes.
// - Thermal bit 3 and switch overcurrent bit 2 latch; read clears only once fault gone.
// - Bit 7 of fault_flags_two latches on watchdog expiry while enabled.
// - Reading fault_flags_two never clears the watchdog flag.
// - Watchdog timer clears by service access or disabling; host services before expiry.
// - Bit 6 of fault_flags_two latches on entry to output hiccup.
// - Hiccup flag stays set during hiccup; read clears only after hiccup left.
// - Bit 5 of fault_flags_two latches when input falls below configured threshold.
// - Read clears input undervoltage flag only while input is above threshold.
// - Bit 4 latches on output overvoltage; read clears only once below threshold.
// - Bit 3 latches on light-load-off entry; read clears only after state left.
// - Bit 2 latches on input overvoltage while powered; read clears once below.
// - Bit 1 sets when a bus command fails or bus data has errors.
// - Reserved bits of both fault registers read as zero; host leaves them alone.
// - Alert output is open-drain: only pulled low or released.
module ffs_fault_flags (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Register access from the serial bus engine
  input  wire logic [7:0]       reg_addr,
  input  wire logic             reg_wr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  output logic                  reg_rvalid,
  // Fault conditions from analog and control logic
  input  wire ffs_pkg::ffs_cond_t fault_cond,
  // Open-drain alert pin
  input  wire logic             alert_pin_n_in,
  output logic                  alert_pin_n_out,
  output logic                  alert_pin_n_oe
);

  ffs_pkg::ffs_state_t s_q;
  ffs_pkg::ffs_state_t s_d;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic               rd_one;
    logic               rd_two;
    logic               wr_release;
    logic               restart_idle;
    logic               any_new;
    logic               any_present;
    logic [7:0]         set_one;
    logic [7:0]         set_two;
    logic [7:0]         clr_one;
    logic [7:0]         clr_two;
    logic [7:0]         new_one;
    logic [7:0]         new_two;
    logic [7:0]         word_one;
    logic [7:0]         word_two;
    logic [7:0]         word_status;
    ffs_pkg::ffs_cond_t c;
    ffs_pkg::ffs_cond_t rise;
    s_d          = s_q;
    c            = s_q.cond_sync;
    rise         = s_q.cond_sync & ~s_q.cond_prev;
    rd_one       = 1'b0;
    rd_two       = 1'b0;
    wr_release   = 1'b0;
    restart_idle = 1'b0;
    any_new      = 1'b0;
    any_present  = 1'b0;
    set_one      = 8'h00;
    set_two      = 8'h00;
    clr_one      = 8'h00;
    clr_two      = 8'h00;
    new_one      = 8'h00;
    new_two      = 8'h00;
    word_one     = 8'h00;
    word_two     = 8'h00;
    word_status  = 8'h00;

    // ****************************************
    // Register access decode
    // ****************************************
    // Reads of either fault register double as the clear-on-read event
    rd_one     = reg_rd && (reg_addr == ffs_pkg::ADDR_FAULT_ONE);
    rd_two     = reg_rd && (reg_addr == ffs_pkg::ADDR_FAULT_TWO);
    // Only the release bit has a write effect, and it is never stored
    wr_release = reg_wr && (reg_addr == ffs_pkg::ADDR_FAULT_ONE) && reg_wdata[ffs_pkg::BIT_ALERT_RELEASE];

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Fault levels and the sensed line come from other domains: two stages before use
    s_d.cond_meta = fault_cond;
    s_d.cond_sync = s_q.cond_meta;
    // Third stage only serves edge detection of the pulse-type faults
    s_d.cond_prev = s_q.cond_sync;
    s_d.pin_meta  = alert_pin_n_in;
    s_d.pin_sync  = s_q.pin_meta;

    // ****************************************
    // Regulator restart delay
    // ****************************************
    // Held at full count while the overcurrent persists, then runs down to zero
    if (c.reg_overcurrent) begin
      s_d.restart_cnt = 32'(ffs_pkg::REG_RESTART_CYCLES);
    end else if (s_q.restart_cnt != 32'h0000_0000) begin
      s_d.restart_cnt = s_q.restart_cnt - 32'h0000_0001;
    end
    restart_idle = (s_q.restart_cnt == 32'h0000_0000);

    // ****************************************
    // First fault register
    // ****************************************
    // Set wins over clear: a read while a level fault persists leaves the flag set

    // Regulator overload: either regulator event sets it; no mask reaches this block
    set_one[ffs_pkg::BIT_REG_OVERLOAD] = c.reg_overcurrent | c.reg_undervoltage;
    if (rd_one && restart_idle) begin
      clr_one[ffs_pkg::BIT_REG_OVERLOAD] = 1'b1;
    end

    // Thermal trip
    set_one[ffs_pkg::BIT_THERMAL] = c.thermal;
    if (rd_one) begin
      clr_one[ffs_pkg::BIT_THERMAL] = 1'b1;
    end

    // Switch overcurrent
    set_one[ffs_pkg::BIT_SWITCH_OC] = c.switch_oc;
    if (rd_one) begin
      clr_one[ffs_pkg::BIT_SWITCH_OC] = 1'b1;
    end

    // Reserved bits and the release bit are never stored
    s_d.fault_one = ((s_q.fault_one & ~clr_one) | set_one) & 8'h1c;

    // ****************************************
    // Second fault register
    // ****************************************
    // Watchdog expiry is taken on its rising edge; no read clears it, only reset
    set_two[ffs_pkg::BIT_WATCHDOG] = rise.watchdog_expired;
    clr_two[ffs_pkg::BIT_WATCHDOG] = 1'b0;

    // Output hiccup: held for the whole restart interval
    set_two[ffs_pkg::BIT_HICCUP] = c.hiccup;
    if (rd_two) begin
      clr_two[ffs_pkg::BIT_HICCUP] = 1'b1;
    end

    // Input undervoltage; the threshold compare happens outside this block
    set_two[ffs_pkg::BIT_INPUT_UV] = c.input_uv;
    if (rd_two) begin
      clr_two[ffs_pkg::BIT_INPUT_UV] = 1'b1;
    end

    // Output overvoltage, from either feedback source
    set_two[ffs_pkg::BIT_OUTPUT_OV] = c.output_ov;
    if (rd_two) begin
      clr_two[ffs_pkg::BIT_OUTPUT_OV] = 1'b1;
    end

    // Light-load shutdown state
    set_two[ffs_pkg::BIT_LIGHT_LOAD] = c.light_load_off;
    if (rd_two) begin
      clr_two[ffs_pkg::BIT_LIGHT_LOAD] = 1'b1;
    end

    // Input overvoltage; the detector only reports it while powered on
    set_two[ffs_pkg::BIT_INPUT_OV] = c.input_ov;
    if (rd_two) begin
      clr_two[ffs_pkg::BIT_INPUT_OV] = 1'b1;
    end

    // Bus error is a pulse from the serial engine, so any later read clears it
    set_two[ffs_pkg::BIT_BUS_ERROR] = rise.bus_error;
    if (rd_two) begin
      clr_two[ffs_pkg::BIT_BUS_ERROR] = 1'b1;
    end

    // Reserved bit is never stored
    s_d.fault_two = ((s_q.fault_two & ~clr_two) | set_two) & 8'hfe;

    // ****************************************
    // Alert
    // ****************************************
    new_one     = s_d.fault_one & ~s_q.fault_one;
    new_two     = s_d.fault_two & ~s_q.fault_two;
    any_new     = (new_one != 8'h00) || (new_two != 8'h00);
    any_present = ((set_one | set_two) != 8'h00);
    // Release drops the alert unless a flag rises in the same cycle
    if (wr_release) begin
      s_d.alert_active = 1'b0;
    end
    if (any_new) begin
      s_d.alert_active = 1'b1;
    end
    // A fault still present re-asserts the alert, so a release cannot hide it
    if (any_present) begin
      s_d.alert_active = 1'b1;
    end
    // Only ever pulled low; the board pull-up gives the high level
    s_d.alert_drive = s_d.alert_active;

    // ****************************************
    // Read data
    // ****************************************
    // Words are built field by field so unused positions read zero
    word_one[ffs_pkg::BIT_REG_OVERLOAD] = s_q.fault_one[ffs_pkg::BIT_REG_OVERLOAD];
    word_one[ffs_pkg::BIT_THERMAL]      = s_q.fault_one[ffs_pkg::BIT_THERMAL];
    word_one[ffs_pkg::BIT_SWITCH_OC]    = s_q.fault_one[ffs_pkg::BIT_SWITCH_OC];
    word_two[ffs_pkg::BIT_WATCHDOG]     = s_q.fault_two[ffs_pkg::BIT_WATCHDOG];
    word_two[ffs_pkg::BIT_HICCUP]       = s_q.fault_two[ffs_pkg::BIT_HICCUP];
    word_two[ffs_pkg::BIT_INPUT_UV]     = s_q.fault_two[ffs_pkg::BIT_INPUT_UV];
    word_two[ffs_pkg::BIT_OUTPUT_OV]    = s_q.fault_two[ffs_pkg::BIT_OUTPUT_OV];
    word_two[ffs_pkg::BIT_LIGHT_LOAD]   = s_q.fault_two[ffs_pkg::BIT_LIGHT_LOAD];
    word_two[ffs_pkg::BIT_INPUT_OV]     = s_q.fault_two[ffs_pkg::BIT_INPUT_OV];
    word_two[ffs_pkg::BIT_BUS_ERROR]    = s_q.fault_two[ffs_pkg::BIT_BUS_ERROR];
    // Live line level as seen through the synchroniser
    word_status[ffs_pkg::BIT_ALERT_LEVEL] = s_q.pin_sync;
    // The release bit always reads zero since it is never stored
    s_d.rvalid = reg_rd;
    s_d.rdata  = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        ffs_pkg::ADDR_FAULT_ONE:  s_d.rdata = word_one;
        ffs_pkg::ADDR_FAULT_TWO:  s_d.rdata = word_two;
        ffs_pkg::ADDR_GEN_STATUS: s_d.rdata = word_status;
        default:                  s_d.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // The sensed line starts high so no false low level follows reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.fault_one    <= ffs_pkg::FAULT_ONE_RESET;
      s_q.fault_two    <= ffs_pkg::FAULT_TWO_RESET;
      s_q.alert_active <= 1'b0;
      s_q.rdata        <= 8'h00;
      s_q.rvalid       <= 1'b0;
      s_q.restart_cnt  <= 32'h0000_0000;
      s_q.alert_drive  <= 1'b0;
      s_q.cond_meta    <= '0;
      s_q.cond_sync    <= '0;
      s_q.cond_prev    <= '0;
      s_q.pin_meta     <= 1'b1;
      s_q.pin_sync     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Open-drain: output data is always low, the enable pulls the line
  assign alert_pin_n_out = 1'b0;
  assign alert_pin_n_oe  = s_q.alert_drive;
  assign reg_rdata       = s_q.rdata;
  assign reg_rvalid      = s_q.rvalid;

endmodule // ffs_fault_flags

//--- tb/ffs_fault_flags_sva.sv
// Checker: port-level properties of the fault flag bank
module ffs_fault_flags_sva (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  // Register access
  input wire logic [7:0]         reg_addr,
  input wire logic               reg_wr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  input wire logic               reg_rvalid,
  // Faults and alert
  input wire ffs_pkg::ffs_cond_t fault_cond,
  input wire logic               alert_pin_n_in,
  input wire logic               alert_pin_n_out,
  input wire logic               alert_pin_n_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // Properties
  // ****************************************
  property p_rel;
    reg_wr && reg_addr == 8'h05 && reg_wdata[7] && fault_cond == 0 && $past(fault_cond) == 0 &&
      $past(fault_cond, 2) == 0 && $past(fault_cond, 3) == 0 |=> !alert_pin_n_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("alert not released");
  property p_hold;
    fault_cond.thermal [*3] ##1 (fault_cond.thermal && reg_wr && reg_addr == 8'h05 && reg_wdata[7]) |=> alert_pin_n_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("alert dropped with fault present");
  property p_pin;
    (!alert_pin_n_in) [*3] ##1 (!alert_pin_n_in && reg_rd && reg_addr == 8'h02) |=> !reg_rdata[6];
  endproperty
  a_pin: assert property (p_pin) else $error("status does not show low line");
  property p_thr;
    reg_rvalid && $past(reg_addr) == 8'h05 && $past(fault_cond.thermal, 2) && $past(fault_cond.thermal, 3) &&
      $past(fault_cond.thermal, 4) |-> reg_rdata[3];
  endproperty
  a_thr: assert property (p_thr) else $error("thermal flag lost while present");
  property p_hic; fault_cond.hiccup [*4] ##1 (reg_rvalid && $past(reg_addr) == 8'h06) |-> reg_rdata[6]; endproperty
  a_hic: assert property (p_hic) else $error("hiccup flag lost while present");
  property p_rsv; reg_rvalid && $past(reg_addr) == 8'h05 |-> (reg_rdata & 8'hE3) == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_od; alert_pin_n_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("alert line driven high");
  property p_set; $rose(fault_cond.thermal) |-> ##[3:4] alert_pin_n_oe; endproperty
  a_set: assert property (p_set) else $error("alert not raised on fault");
  c_rel: cover property (reg_wr && reg_addr == 8'h05 && reg_wdata[7]);
  c_wd: cover property (reg_rvalid && reg_rdata[7]);
  c_oe: cover property ($fell(alert_pin_n_oe));
endmodule // ffs_fault_flags_sva

//--- tb/ffs_alert_line.sv
// Partner model: open-drain alert line with pull-up and an external sink
module ffs_alert_line (
  // Device side
  input  wire logic oe,
  input  wire logic data,
  // Board side
  input  wire logic ext_low,
  output logic      level_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released line floats up through the pull-up; any sink wins
  assign level_n = (oe ? data : 1'b1) && !ext_low;
endmodule // ffs_alert_line

//--- tb/testbench.sv
// Testbench: register reads, fault latching and alert release
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, ext_low = 1'b0, rvalid, level_n, pin_out, oe;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  ffs_pkg::ffs_cond_t cond = '0;
  int mismatches = 0, check_count = 0, cycles = 0;
  always #25 clk = ~clk;
  ffs_fault_flags ffs_fault_flags_inst (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr(wr_s), .reg_wdata(wdata),
    .reg_rd(rd_s), .reg_rdata(rdata), .reg_rvalid(rvalid), .fault_cond(cond), .alert_pin_n_in(level_n),
    .alert_pin_n_out(pin_out), .alert_pin_n_oe(oe));
  ffs_alert_line ffs_alert_line_inst (.oe(oe), .data(pin_out), .ext_low(ext_low), .level_n(level_n));
  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    tick(1);
    wr_s = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask = 8'hFF);
    addr = a;
    rd_s = 1'b1;
    tick(1);
    rd_s = 1'b0;
    chk8({7'h00, rvalid}, 8'h01);
    chk8(rdata & mask, exp);
    tick(1);
  endtask
  task automatic pulse(input int i);
    cond[i] = 1'b1;
    tick(4);
    cond[i] = 1'b0;
    tick(4);
  endtask
  // Read while present must keep the flag, read after it is gone clears it
  task automatic lvl(input int i, input logic [7:0] a, input logic [7:0] e);
    cond[i] = 1'b1;
    tick(4);
    rd(a, e);
    cond[i] = 1'b0;
    tick(4);
    rd(a, e);
    rd(a, 8'h00);
    wr(8'h05, 8'h80);
    chk8({7'h00, oe}, 8'h00);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    tick(3);
    rst_n = 1'b1;
    chk8({7'h00, pin_out}, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h02, 8'h40, 8'h40);
    ext_low = 1'b1;
    tick(3);
    rd(8'h02, 8'h00, 8'h40);
    ext_low = 1'b0;
    cond.thermal = 1'b1;
    tick(4);
    chk8({7'h00, oe}, 8'h01);
    wr(8'h05, 8'h80);
    chk8({7'h00, oe}, 8'h01);
    rd(8'h05, 8'h08);
    cond.thermal = 1'b0;
    tick(4);
    rd(8'h05, 8'h08);
    rd(8'h05, 8'h00);
    wr(8'h05, 8'h80);
    chk8({7'h00, oe}, 8'h00);
    rd(8'h05, 8'h00);
    lvl(7, 8'h05, 8'h04);
    lvl(9, 8'h05, 8'h10);
    lvl(5, 8'h06, 8'h40);
    lvl(4, 8'h06, 8'h20);
    lvl(3, 8'h06, 8'h10);
    lvl(2, 8'h06, 8'h08);
    lvl(1, 8'h06, 8'h04);
    pulse(0);
    chk8({7'h00, oe}, 8'h01);
    rd(8'h06, 8'h02);
    rd(8'h06, 8'h00);
    wr(8'h05, 8'h80);
    chk8({7'h00, oe}, 8'h00);
    pulse(10);
    rd(8'h05, 8'h10);
    rd(8'h05, 8'h10);
    pulse(6);
    rd(8'h06, 8'h80);
    rd(8'h06, 8'h80);
    wr(8'h06, 8'hFF);
    rd(8'h06, 8'h80);
    test_done();
  end
endmodule // testbench
bind ffs_fault_flags ffs_fault_flags_sva ffs_fault_flags_sva_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .fault_cond(fault_cond), .alert_pin_n_in(alert_pin_n_in), .alert_pin_n_out(alert_pin_n_out),
  .alert_pin_n_oe(alert_pin_n_oe));
